// ==== pmic_host_register_port.sv ====
/*
 Host register port: two two-wire slaves (configuration and voltage scaling)
 or one four-wire slave, sharing four pins, in front of paged byte registers.
 Assumes open-drain resolution of the two-way pins outside, and a static
 factory strap choosing the four-wire option.
*/
// Summary of operation
// - Slave only, seven-bit addresses; no ten-bit, general call or mastering.
// - Two-wire ports run standard, fast and high-speed with one protocol.
// - Configuration base address 010010xx; low two bits pick the page.
// - Four pages of REG_COUNT (64) bytes at ascending addresses 0x48 to 0x4B.
// - Voltage port answers fixed address 0x12, never remapped.
// - Each page remap bit moves that page to 0x58 through 0x5B.
// - Voltage port works concurrently with the configuration port.
// - Start is data falling with clock high; stop is data rising.
// - Matching address acknowledged through ninth clock high; otherwise silent.
// - Receiver acknowledges every byte; byte groups repeat for any length.
// - After stop, bus ignored until start plus matching address.
// - Reads of undefined register addresses return 0xFF.
// - High-speed master code is not acknowledged but enables high speed.
// - High speed survives repeated start; stop returns to normal timing.
// - Host drives select, clock, data in; data out idles high impedance.
// - Frame MSB first: direction, page, register, burst, four unused, data.
// - Direction 0 reads, 1 writes; burst 0 single, 1 burst.
// - Read data out invalid during unused bits, valid afterwards; none on writes.
// - Burst access increments register address after each whole data byte.
// - Select dropped mid-byte discards the unfinished final byte.
// - Two-wire and four-wire options exclusive by factory strap, same pins.
// - Voltage port reaches only the voltage-scaling registers.
`timescale 1ns/10ps
module pmic_host_register_port #(
  parameter int REG_COUNT = 64
) (
  // System clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Factory option and page remap
  input  wire logic       spiModeStrap,
  input  wire logic [3:0] pageAddressRemapBits,
  // Configuration clock, or four-wire clock
  input  wire logic       cfgClockOrSpiClockPin,
  // Configuration data, or four-wire data in
  input  wire logic       cfgDataOrSpiInPinIn,
  output logic            cfgDataOrSpiInPinOut,
  output logic            cfgDataOrSpiInPinOe,
  // Voltage clock, or four-wire select
  input  wire logic       voltClockOrSpiSelectPin,
  // Voltage data, or four-wire data out
  input  wire logic       voltDataOrSpiOutPinIn,
  output logic            voltDataOrSpiOutPinOut,
  output logic            voltDataOrSpiOutPinOe,
  // Status
  output logic            spiModeActive,
  output logic            cfgHighSpeed,
  output logic            voltHighSpeed
);
  import pmic_port_pkg::*;

  localparam int AW = $clog2(REG_COUNT);

  // System clock domain state
  typedef struct packed {
    logic       mode;
    logic [1:0] cfgScl;
    logic [1:0] cfgSda;
    logic [1:0] vScl;
    logic [1:0] vSda;
    logic [1:0] tog;
    logic       seen;
    logic [7:0] spiRd;
    logic       cfgOe;
    logic       voltOe;
    logic       cfgHs;
    logic       voltHs;
  } sys_t;

  // Four-wire frame state, cleared by select low
  typedef struct packed {
    logic [4:0]  cnt;
    logic [11:0] hdr;
    logic [7:0]  dsh;
    logic [2:0]  dbit;
    logic [7:0]  addr;
    logic        done;
  } frame_t;

  // Four-wire request holder
  typedef struct packed {
    logic tog;
    acc_t req;
  } req_t;

  // Four-wire output side, falling edge
  typedef struct packed {
    logic [7:0] txByte;
    logic       serial_data_out;
    logic       oe;
  } tx_t;

  localparam sys_t SYS_RST = '{mode: 1'b0, cfgScl: 2'h3, cfgSda: 2'h3, vScl: 2'h3, vSda: 2'h3,
                               tog: 2'h0, seen: 1'b0, spiRd: UNDEF_DATA, cfgOe: 1'b0,
                               voltOe: 1'b0, cfgHs: 1'b0, voltHs: 1'b0};
  localparam frame_t FR_RST = '{cnt: 5'h00, hdr: 12'h000, dsh: 8'h00, dbit: 3'h0,
                                addr: 8'h00, done: 1'b0};
  localparam req_t RQ_RST = '{tog: 1'b0, req: '{wr: 1'b0, page: 2'h0, addr: 8'h00, data: 8'h00}};
  localparam tx_t TX_RST = '{txByte: 8'h00, serial_data_out: 1'b0, oe: 1'b0};

  sys_t   q;
  sys_t   d;
  frame_t fq;
  frame_t fd;
  req_t   rq;
  req_t   rd;
  tx_t    tq;
  tx_t    td;

  logic [7:0]              mem [PAGE_COUNT*REG_COUNT];
  logic [PAGE_COUNT-1:0][6:0] cfgAddrs;
  logic [0:0][6:0]         voltAddrs;
  acc_t                    cfgAcc;
  acc_t                    voltAcc;
  logic [7:0]              cfgRdData;
  logic [7:0]              voltRdData;
  logic                    cfgOe;
  logic                    voltOe;
  logic                    cfgHs;
  logic                    voltHs;
  logic                    spiEvt;
  logic                    issue;
  acc_t                    issueAcc;
  logic [11:0]             hdrNext;
  logic [7:0]              byteNext;
  logic                    spiRead;
  logic                    spiBurst;

  function automatic logic [AW+1:0] idx(input logic [1:0] page, input logic [7:0] addr);
    idx = {page, addr[AW-1:0]};
  endfunction

  function automatic logic [7:0] rdByte(input logic [1:0] page, input logic [7:0] addr);
    rdByte = UNDEF_DATA;
    if (32'(addr) < REG_COUNT) begin
      rdByte = mem[idx(page, addr)];
    end
  endfunction

  function automatic logic voltOk(input logic [7:0] addr);
    voltOk = (addr >= VOLT_FIRST) && (addr <= VOLT_LAST);
  endfunction

  // Page addresses, each remappable
  always_comb begin
    for (int i = 0; i < PAGE_COUNT; i++) begin
      cfgAddrs[i] = (pageAddressRemapBits[i] ? CFG_ADDR_ALT : CFG_ADDR_BASE) + 7'(i);
    end
    voltAddrs[0] = VOLT_ADDR;
  end

  // Follows storage writes as well as the pointers
  always_comb begin
    cfgRdData  = rdByte(cfgAcc.page, cfgAcc.addr);
    voltRdData = voltOk(voltAcc.addr) ? rdByte(VOLT_PAGE, voltAcc.addr) : UNDEF_DATA;
  end

  i2c_slave_port #(
    .NUM_ADDR (PAGE_COUNT)
  ) cfgPort (
    .clk       (clk),
    .rst_n     (rst_n),
    .enable    (!q.mode),
    .sclIn     (q.cfgScl[1]),
    .sdaIn     (q.cfgSda[1]),
    .slaveAddr (cfgAddrs),
    .acc       (cfgAcc),
    .rdData    (cfgRdData),
    .sdaOe     (cfgOe),
    .highSpeed (cfgHs)
  );

  // Independent engine, runs alongside the configuration port
  i2c_slave_port #(
    .NUM_ADDR (1)
  ) voltPort (
    .clk       (clk),
    .rst_n     (rst_n),
    .enable    (!q.mode),
    .sclIn     (q.vScl[1]),
    .sdaIn     (q.vSda[1]),
    .slaveAddr (voltAddrs),
    .acc       (voltAcc),
    .rdData    (voltRdData),
    .sdaOe     (voltOe),
    .highSpeed (voltHs)
  );

  assign spiEvt = q.mode && (q.tog[1] != q.seen);

  always_comb begin
    d        = q;
    d.cfgScl = {q.cfgScl[0], cfgClockOrSpiClockPin};
    d.cfgSda = {q.cfgSda[0], cfgDataOrSpiInPinIn};
    d.vScl   = {q.vScl[0], voltClockOrSpiSelectPin};
    d.vSda   = {q.vSda[0], voltDataOrSpiOutPinIn};
    d.tog    = {q.tog[0], rq.tog};
    d.seen   = q.tog[1];
    if (spiEvt && !rq.req.wr) begin
      d.spiRd = rdByte(rq.req.page, rq.req.addr);
    end
    d.cfgOe  = !q.mode && cfgOe;
    d.voltOe = !q.mode && voltOe;
    d.cfgHs  = cfgHs;
    d.voltHs = voltHs;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q      <= SYS_RST;
      q.mode <= spiModeStrap;
    end else begin
      q <= d;
    end
  end

  // Register storage; later write wins on a shared address
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < PAGE_COUNT*REG_COUNT; i++) begin
        mem[i] <= RESET_BYTE;
      end
    end else begin
      if (cfgAcc.wr && (32'(cfgAcc.addr) < REG_COUNT)) begin
        mem[idx(cfgAcc.page, cfgAcc.addr)] <= cfgAcc.data;
      end
      if (voltAcc.wr && voltOk(voltAcc.addr) && (32'(voltAcc.addr) < REG_COUNT)) begin
        mem[idx(VOLT_PAGE, voltAcc.addr)] <= voltAcc.data;
      end
      if (spiEvt && rq.req.wr && (32'(rq.req.addr) < REG_COUNT)) begin
        mem[idx(rq.req.page, rq.req.addr)] <= rq.req.data;
      end
    end
  end

  // Four-wire receive side
  assign hdrNext  = {fq.hdr[10:0], cfgDataOrSpiInPinIn};
  assign byteNext = {fq.dsh[6:0], cfgDataOrSpiInPinIn};
  assign spiRead  = fq.hdr[SPI_RW_BIT] != SPI_DIR_WRITE;
  assign spiBurst = fq.hdr[SPI_BURST_BIT];

  always_comb begin
    fd       = fq;
    issue    = 1'b0;
    issueAcc = RQ_RST.req;
    if (fq.cnt != SPI_HDR_BITS) begin
      fd.cnt = fq.cnt + 5'h01;
      if (fq.cnt < SPI_FETCH_BITS) begin
        fd.hdr = hdrNext;
      end
      if (fq.cnt == SPI_FETCH_BITS - 5'h01) begin
        fd.addr       = hdrNext[SPI_ADDR_LSB +: 8];
        issue         = hdrNext[SPI_RW_BIT] != SPI_DIR_WRITE;
        issueAcc.page = hdrNext[SPI_PAGE_LSB +: 2];
        issueAcc.addr = hdrNext[SPI_ADDR_LSB +: 8];
      end
    end else if (!fq.done) begin
      fd.dsh  = byteNext;
      fd.dbit = fq.dbit + 3'h1;
      if (fq.dbit == 3'h7) begin
        if (!spiRead) begin
          issue         = 1'b1;
          issueAcc.wr   = 1'b1;
          issueAcc.page = fq.hdr[SPI_PAGE_LSB +: 2];
          issueAcc.addr = fq.addr;
          issueAcc.data = byteNext;
        end
        if (spiBurst) begin
          fd.addr = fq.addr + 8'h01;
        end else begin
          fd.done = 1'b1;
        end
      end else if ((fq.dbit == 3'h0) && spiBurst && spiRead) begin
        issue         = 1'b1;
        issueAcc.page = fq.hdr[SPI_PAGE_LSB +: 2];
        issueAcc.addr = fq.addr + 8'h01;
      end
    end
  end

  // Select low ends the frame and drops a partial byte
  always_ff @(posedge cfgClockOrSpiClockPin or negedge voltClockOrSpiSelectPin) begin
    if (!voltClockOrSpiSelectPin) begin
      fq <= FR_RST;
    end else begin
      fq <= fd;
    end
  end

  // Request word held until the next one; toggle marks it
  always_comb begin
    rd = rq;
    if (issue) begin
      rd.tog = !rq.tog;
      rd.req = issueAcc;
    end
  end

  always_ff @(posedge cfgClockOrSpiClockPin or negedge rst_n) begin
    if (!rst_n) begin
      rq <= RQ_RST;
    end else begin
      rq <= rd;
    end
  end

  // Four-wire transmit side
  always_comb begin
    td    = tq;
    td.oe = 1'b0;
    if ((fq.cnt == SPI_HDR_BITS) && !fq.done && spiRead) begin
      td.oe = 1'b1;
      if (fq.dbit == 3'h0) begin
        td.txByte = q.spiRd;
        td.serial_data_out    = q.spiRd[7];
      end else begin
        td.serial_data_out = tq.txByte[3'h7 - fq.dbit];
      end
    end
  end

  always_ff @(negedge cfgClockOrSpiClockPin or negedge voltClockOrSpiSelectPin) begin
    if (!voltClockOrSpiSelectPin) begin
      tq <= TX_RST;
    end else begin
      tq <= td;
    end
  end

  // Pin drive follows the factory option
  assign cfgDataOrSpiInPinOut   = 1'b0;
  assign cfgDataOrSpiInPinOe    = q.cfgOe;
  assign voltDataOrSpiOutPinOut = q.mode ? tq.serial_data_out : 1'b0;
  assign voltDataOrSpiOutPinOe  = q.mode ? tq.oe : q.voltOe;
  assign spiModeActive          = q.mode;
  assign cfgHighSpeed           = q.cfgHs;
  assign voltHighSpeed          = q.voltHs;
endmodule

// ==== pmic_port_pkg.sv ====
/*
 Shared constants and types for the host register port.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package pmic_port_pkg;
  localparam int         PAGE_COUNT     = 4;
  localparam logic [6:0] CFG_ADDR_BASE  = 7'h48;
  localparam logic [6:0] CFG_ADDR_ALT   = 7'h58;
  localparam logic [6:0] VOLT_ADDR      = 7'h12;
  localparam logic [4:0] HS_CODE_TOP    = 5'h01;
  localparam logic [7:0] UNDEF_DATA     = 8'hff;
  localparam logic [7:0] RESET_BYTE     = 8'h00;
  localparam logic [7:0] VOLT_FIRST     = 8'h20;
  localparam logic [7:0] VOLT_LAST      = 8'h2f;
  localparam logic [1:0] VOLT_PAGE      = 2'h0;
  localparam logic [4:0] SPI_HDR_BITS   = 5'h10;
  localparam logic [4:0] SPI_FETCH_BITS = 5'h0c;
  localparam int         SPI_RW_BIT     = 11;
  localparam int         SPI_PAGE_LSB   = 9;
  localparam int         SPI_ADDR_LSB   = 1;
  localparam int         SPI_BURST_BIT  = 0;
  localparam logic       SPI_DIR_WRITE  = 1'b1;

  typedef struct packed {
    logic       wr;
    logic [1:0] page;
    logic [7:0] addr;
    logic [7:0] data;
  } acc_t;

  typedef enum logic [2:0] {
    I2C_IDLE  = 3'b000,
    I2C_ADDR  = 3'b001,
    I2C_REG   = 3'b010,
    I2C_WDATA = 3'b011,
    I2C_RDATA = 3'b100
  } i2c_state_t;
endpackage

// ==== i2c_slave_port.sv ====
/*
 Two-wire slave engine: start and stop detection, address match, register
 pointer, byte receive and transmit with acknowledge.
 Assumes the bus lines are already synchronised to clk.
*/
`timescale 1ns/10ps
module i2c_slave_port #(
  parameter int NUM_ADDR = 4
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // Enable and synchronised bus lines
  input  wire logic                     enable,
  input  wire logic                     sclIn,
  input  wire logic                     sdaIn,
  // Addresses answered, index is the page
  input  wire logic [NUM_ADDR-1:0][6:0] slaveAddr,
  // Register access
  output pmic_port_pkg::acc_t           acc,
  input  wire logic [7:0]               rdData,
  // Line pull-down and speed mode
  output logic                          sdaOe,
  output logic                          highSpeed
);
  import pmic_port_pkg::*;

  typedef struct packed {
    i2c_state_t st;
    logic       sclP;
    logic       sdaP;
    logic [3:0] bits;
    logic [7:0] shift;
    logic [1:0] page;
    logic [7:0] addr;
    logic       nack;
    logic       oe;
    logic       hs;
    logic       wr;
  } port_t;

  localparam port_t PORT_RST = '{st: I2C_IDLE, sclP: 1'b1, sdaP: 1'b1, bits: 4'h0, shift: 8'h00,
                                 page: 2'h0, addr: 8'h00, nack: 1'b1, oe: 1'b0, hs: 1'b0, wr: 1'b0};

  port_t      q;
  port_t      d;
  logic [2:0] hitV;
  logic       startCond;
  logic       stopCond;

  function automatic logic [2:0] match(input logic [6:0] a);
    match = 3'h0;
    for (int i = 0; i < NUM_ADDR; i++) begin
      if (slaveAddr[i] == a) begin
        match = {1'b1, 2'(i)};
      end
    end
  endfunction

  assign startCond = q.sclP && sclIn && q.sdaP && !sdaIn;
  assign stopCond  = q.sclP && sclIn && !q.sdaP && sdaIn;

  always_comb begin
    hitV   = match(q.shift[7:1]);
    d      = q;
    d.sclP = sclIn;
    d.sdaP = sdaIn;
    d.wr   = 1'b0;
    if (q.wr) begin
      d.addr = q.addr + 8'h01;
    end
    if (!enable) begin
      d = PORT_RST;
    end else if (startCond) begin
      d.st   = I2C_ADDR;
      d.bits = 4'h0;
      d.oe   = 1'b0;
    end else if (stopCond) begin
      d.st = I2C_IDLE;
      d.oe = 1'b0;
      d.hs = 1'b0;
    end else if (q.st != I2C_IDLE) begin
      // Same bit engine for every speed
      if (!q.sclP && sclIn) begin
        d.bits = q.bits + 4'h1;
        if (q.bits < 4'h8) begin
          d.shift = {q.shift[6:0], sdaIn};
        end else begin
          d.nack = sdaIn;
        end
      end else if (q.sclP && !sclIn) begin
        if (q.bits == 4'h8) begin
          d.oe = 1'b1;
          unique case (q.st)
            I2C_ADDR: begin
              if (q.shift[7:3] == HS_CODE_TOP) begin
                d.oe = 1'b0;
                d.hs = 1'b1;
                d.st = I2C_IDLE;
              end else if (hitV[2]) begin
                d.page = hitV[1:0];
                d.st   = q.shift[0] ? I2C_RDATA : I2C_REG;
              end else begin
                d.oe = 1'b0;
                d.st = I2C_IDLE;
              end
            end
            I2C_REG: begin
              d.addr = q.shift;
              d.st   = I2C_WDATA;
            end
            I2C_WDATA: begin
              d.wr = 1'b1;
            end
            I2C_RDATA: begin
              d.oe = 1'b0;
            end
            default: begin
              d.oe = 1'b0;
            end
          endcase
        end else if (q.bits == 4'h9) begin
          d.bits = 4'h0;
          d.oe   = 1'b0;
          if (q.st == I2C_RDATA) begin
            if (q.nack) begin
              d.st = I2C_IDLE;
            end else begin
              d.shift = rdData;
              d.addr  = q.addr + 8'h01;
              d.oe    = !rdData[7];
            end
          end
        end else if (q.st == I2C_RDATA) begin
          // Each rise shifts the register, so the next bit is at the top
          d.oe = !q.shift[7];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= PORT_RST;
    end else begin
      q <= d;
    end
  end

  assign acc       = '{wr: q.wr, page: q.page, addr: q.addr, data: q.shift};
  assign sdaOe     = q.oe;
  assign highSpeed = q.hs;
endmodule

// ==== pmic_host_register_port_sva.sv ====
/*
 Port assertions for the host register port.
 Assumes a bind onto pmic_host_register_port; all checks sample on clk.
*/
`timescale 1ns/10ps
module pmic_host_register_port_sva #(
  parameter int REG_COUNT = 64
) (
  // Clock, reset and option
  input wire logic clk,
  input wire logic rst_n,
  input wire logic spiModeStrap,
  // Pins
  input wire logic cfgClockOrSpiClockPin,
  input wire logic cfgDataOrSpiInPinIn,
  input wire logic cfgDataOrSpiInPinOut,
  input wire logic cfgDataOrSpiInPinOe,
  input wire logic voltClockOrSpiSelectPin,
  input wire logic voltDataOrSpiOutPinIn,
  input wire logic voltDataOrSpiOutPinOut,
  input wire logic voltDataOrSpiOutPinOe,
  // Status
  input wire logic spiModeActive,
  input wire logic cfgHighSpeed,
  input wire logic voltHighSpeed
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence cfgStop;
    !spiModeActive && cfgClockOrSpiClockPin && $rose(cfgDataOrSpiInPinIn);
  endsequence
  sequence voltStop;
    !spiModeActive && voltClockOrSpiSelectPin && $rose(voltDataOrSpiOutPinIn);
  endsequence
  sequence cfgHsStart;
    !spiModeActive && cfgHighSpeed && cfgClockOrSpiClockPin && $fell(cfgDataOrSpiInPinIn);
  endsequence

  a_cfg_hs_stop: assert property (cfgStop |-> ##[1:8] !cfgHighSpeed)
    else $error("config high speed kept after stop");
  a_volt_hs_stop: assert property (voltStop |-> ##[1:8] !voltHighSpeed)
    else $error("voltage high speed kept after stop");
  a_hs_start_keep: assert property (cfgHsStart |=> cfgHighSpeed [*6])
    else $error("high speed lost at repeated start");
  a_cfg_oe_timing: assert property (!spiModeActive && $changed(cfgDataOrSpiInPinOe)
    |-> !cfgClockOrSpiClockPin)
    else $error("config data drive changed with clock high");
  a_volt_oe_timing: assert property (!spiModeActive && $changed(voltDataOrSpiOutPinOe)
    |-> !voltClockOrSpiSelectPin)
    else $error("voltage data drive changed with clock high");
  a_sdo_idle_off: assert property (spiModeActive && !voltClockOrSpiSelectPin
    |-> !voltDataOrSpiOutPinOe)
    else $error("data out driven without select");
  a_cfg_spi_quiet: assert property (spiModeActive |-> !cfgDataOrSpiInPinOe)
    else $error("data in pin driven in four-wire option");
  a_drain_only: assert property (!spiModeActive
    |-> !cfgDataOrSpiInPinOut && !voltDataOrSpiOutPinOut)
    else $error("two-wire pin driven high");
  a_strap_capture: assert property ($rose(rst_n) |-> spiModeActive == $past(spiModeStrap))
    else $error("option strap not captured");
endmodule

bind pmic_host_register_port pmic_host_register_port_sva #(.REG_COUNT(REG_COUNT)) u_pmic_host_register_port_sva (
  .clk(clk), .rst_n(rst_n), .spiModeStrap(spiModeStrap),
  .cfgClockOrSpiClockPin(cfgClockOrSpiClockPin), .cfgDataOrSpiInPinIn(cfgDataOrSpiInPinIn),
  .cfgDataOrSpiInPinOut(cfgDataOrSpiInPinOut), .cfgDataOrSpiInPinOe(cfgDataOrSpiInPinOe),
  .voltClockOrSpiSelectPin(voltClockOrSpiSelectPin), .voltDataOrSpiOutPinIn(voltDataOrSpiOutPinIn),
  .voltDataOrSpiOutPinOut(voltDataOrSpiOutPinOut), .voltDataOrSpiOutPinOe(voltDataOrSpiOutPinOe),
  .spiModeActive(spiModeActive), .cfgHighSpeed(cfgHighSpeed), .voltHighSpeed(voltHighSpeed)
);

// ==== i2c_host_model.sv ====
/*
 Bit-level two-wire bus master standing in for the host.
 Assumes the bench resolves the open-drain line into sdaLine.
*/
`timescale 1ns/10ps
module i2c_host_model #(
  parameter int QTR = 300
) (
  // Bus lines
  output logic      scl,
  output logic      sda,
  input  wire logic sdaLine
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic startCond();
    sda = 1'b1;
    #QTR scl = 1'b1;
    #QTR sda = 1'b0;
    #QTR scl = 1'b0;
  endtask
  task automatic stopCond();
    sda = 1'b0;
    #QTR scl = 1'b1;
    #QTR sda = 1'b1;
    #QTR;
  endtask
  // Data changes only while the clock is low
  task automatic bitx(input logic b, output logic s);
    sda = b;
    #QTR scl = 1'b1;
    #QTR s = sdaLine;
    #QTR scl = 1'b0;
    #QTR;
  endtask
  task automatic xfer(input logic [7:0] tx, input logic ai, output logic [7:0] rx, output logic ao);
    for (int i = 7; i >= 0; i--) bitx(tx[i], rx[i]);
    bitx(ai, ao);
  endtask
endmodule

// ==== pmic_host_register_port_test.sv ====
/*
 Self-checking bench: two-wire traffic on both ports, then four-wire frames.
 Assumes the host model and the bound checker.
*/
`timescale 1ns/10ps
module pmic_host_register_port_test;
  import pmic_port_pkg::*;
  logic       clk, rst_n, strap, sck, sel, serial_data_in, cfgScl, cfgSdaM, voltScl, voltSdaM;
  logic       cfgOe, voltOe, voltOut, spiAct, cfgHs, voltHs, cfgLine, voltLine;
  logic [3:0] remap;
  logic [7:0] q[$];
  int         fails, n_compared;

  assign cfgLine  = cfgSdaM & ~cfgOe;
  assign voltLine = voltSdaM & ~voltOe;
  pmic_host_register_port #(.REG_COUNT(64)) u_pmic_host_register_port (
    .clk(clk), .rst_n(rst_n), .spiModeStrap(strap), .pageAddressRemapBits(remap),
    .cfgClockOrSpiClockPin(strap ? sck : cfgScl), .cfgDataOrSpiInPinIn(strap ? serial_data_in : cfgLine),
    .cfgDataOrSpiInPinOut(), .cfgDataOrSpiInPinOe(cfgOe),
    .voltClockOrSpiSelectPin(strap ? sel : voltScl), .voltDataOrSpiOutPinIn(voltLine),
    .voltDataOrSpiOutPinOut(voltOut), .voltDataOrSpiOutPinOe(voltOe),
    .spiModeActive(spiAct), .cfgHighSpeed(cfgHs), .voltHighSpeed(voltHs)
  );
  i2c_host_model u_cfg_host (.scl(cfgScl), .sda(cfgSdaM), .sdaLine(cfgLine));
  i2c_host_model u_volt_host (.scl(voltScl), .sda(voltSdaM), .sdaLine(voltLine));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic test_done();
    $display("compared %0d, fails %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic doReset(input logic s);
    @(negedge clk);
    rst_n = 1'b0;
    strap = s;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask
  task automatic bs(input bit p);
    if (p) u_volt_host.startCond();
    else u_cfg_host.startCond();
  endtask
  task automatic bp(input bit p);
    if (p) u_volt_host.stopCond();
    else u_cfg_host.stopCond();
  endtask
  task automatic bx(input bit p, input logic [7:0] tx, input logic ai, output logic [7:0] rx, output logic ao);
    if (p) u_volt_host.xfer(tx, ai, rx, ao);
    else u_cfg_host.xfer(tx, ai, rx, ao);
  endtask
  task automatic hdr(input bit p, input logic [6:0] a, input logic [7:0] r);
    logic [7:0] rx;
    logic       ao;
    bs(p);
    bx(p, {a, 1'b0}, 1'b1, rx, ao);
    check("address ack", {7'h0, ao}, 8'h00);
    bx(p, r, 1'b1, rx, ao);
    check("register ack", {7'h0, ao}, 8'h00);
  endtask
  task automatic regWr(input bit p, input logic [6:0] a, input logic [7:0] r, input logic [7:0] d[$]);
    logic [7:0] rx;
    logic       ao;
    hdr(p, a, r);
    foreach (d[i]) begin
      bx(p, d[i], 1'b1, rx, ao);
      check("data ack", {7'h0, ao}, 8'h00);
    end
    bp(p);
  endtask
  task automatic regRd(input bit p, input logic [6:0] a, input logic [7:0] r, input logic [7:0] e[$]);
    logic [7:0] rx;
    logic       ao;
    hdr(p, a, r);
    bs(p);
    bx(p, {a, 1'b1}, 1'b1, rx, ao);
    check("read address ack", {7'h0, ao}, 8'h00);
    foreach (e[i]) begin
      bx(p, 8'hff, i == e.size() - 1, rx, ao);
      check("read data", rx, e[i]);
    end
    bp(p);
  endtask
  task automatic probe(input bit p, input logic [6:0] a, input logic nack);
    logic [7:0] rx;
    logic       ao;
    bs(p);
    bx(p, {a, 1'b0}, 1'b1, rx, ao);
    check("address answer", {7'h0, ao}, {7'h0, nack});
    bp(p);
  endtask
  task automatic sbit(input logic b, input logic pz, input logic eo, output logic s);
    serial_data_in = b;
    #7.5 sck = 1'b1;
    s = voltOut;
    check("data out enable", {7'h0, voltOe}, {7'h0, eo});
    if (pz) #900;
    #7.5 sck = 1'b0;
  endtask
  task automatic spi(input logic w, input logic [1:0] pg, input logic [7:0] r, input logic b,
                     input logic [7:0] d[$], input int tail, output logic [7:0] qo[$]);
    logic [15:0] h;
    logic [7:0]  v;
    logic        s;
    h = {w, pg, r, b, 4'h0};
    qo = {};
    #3 sel = 1'b1;
    for (int i = 15; i >= 0; i--) sbit(h[i], i <= 4, 1'b0, s);
    foreach (d[j]) begin
      for (int k = 7; k >= 0; k--) sbit(d[j][k], 1'b1, !w && (b || j == 0), v[k]);
      qo.push_back(v);
    end
    for (int k = 0; k < tail; k++) sbit(1'b1, 1'b1, 1'b0, s);
    #20 sel = 1'b0;
    serial_data_in = ~serial_data_in;
    #20;
    check("idle data out enable", {7'h0, voltOe}, 8'h00);
  endtask

  initial begin
    #5000000;
    fails++;
    test_done();
  end

  initial begin
    logic [7:0] rx;
    logic       ao;
    rst_n = 1'b0;
    strap = 1'b0;
    remap = 4'h0;
    sck = 1'b0;
    sel = 1'b0;
    serial_data_in = 1'b0;
    fails = 0;
    n_compared = 0;
    doReset(1'b0);
    regWr(1'b0, CFG_ADDR_BASE, 8'h05, {8'ha5, 8'h5a});
    regRd(1'b0, CFG_ADDR_BASE, 8'h05, {8'ha5, 8'h5a});
    regRd(1'b0, CFG_ADDR_BASE, 8'h40, {8'hff});
    for (int m = 0; m < 2; m++) begin
      @(negedge clk) remap = (m == 1) ? 4'ha : 4'h0;
      for (int i = 0; i < 4; i++) begin
        probe(1'b0, 7'(CFG_ADDR_BASE + i), remap[i]);
        probe(1'b0, 7'(CFG_ADDR_ALT + i), !remap[i]);
      end
    end
    regWr(1'b0, 7'(CFG_ADDR_ALT + 1), 8'h06, {8'h3c});
    @(negedge clk) remap = 4'hf;
    probe(1'b1, VOLT_ADDR, 1'b0);
    @(negedge clk) remap = 4'h0;
    regRd(1'b0, 7'(CFG_ADDR_BASE + 1), 8'h06, {8'h3c});
    regRd(1'b0, CFG_ADDR_BASE, 8'h06, {8'h5a});
    probe(1'b0, 7'h00, 1'b1);
    fork
      regWr(1'b0, CFG_ADDR_BASE, 8'h22, {8'h11});
      regWr(1'b1, VOLT_ADDR, 8'h21, {8'h77});
    join
    regRd(1'b1, VOLT_ADDR, 8'h21, {8'h77, 8'h11});
    regRd(1'b1, VOLT_ADDR, 8'h05, {8'hff});
    bx(1'b0, 8'h90, 1'b1, rx, ao);
    check("ack without start", {7'h0, ao}, 8'h01);
    bp(1'b0);
    for (int k = 0; k < 8; k++) begin
      bs(k[0]);
      bx(k[0], {HS_CODE_TOP, 3'(k)}, 1'b1, rx, ao);
      check("code ack", {7'h0, ao}, 8'h01);
      hdr(k[0], k[0] ? VOLT_ADDR : CFG_ADDR_BASE, 8'h05);
      check("high speed", {7'h0, k[0] ? voltHs : cfgHs}, 8'h01);
      bp(k[0]);
      repeat (10) @(posedge clk);
      check("speed after stop", {7'h0, k[0] ? voltHs : cfgHs}, 8'h00);
    end
    doReset(1'b1);
    check("four-wire option", {7'h0, spiAct}, 8'h01);
    spi(1'b1, 2'h1, 8'h07, 1'b0, {8'hc3, 8'h5a}, 0, q);
    spi(1'b0, 2'h1, 8'h07, 1'b1, {8'h00, 8'h00}, 0, q);
    check("single write", q[0], 8'hc3);
    check("extra byte dropped", q[1], 8'h00);
    spi(1'b1, 2'h2, 8'h10, 1'b1, {8'h11, 8'h22}, 4, q);
    spi(1'b0, 2'h2, 8'h10, 1'b1, {8'h00, 8'h00, 8'h00}, 0, q);
    check("burst first", q[0], 8'h11);
    check("burst second", q[1], 8'h22);
    check("partial byte", q[2], 8'h00);
    spi(1'b0, 2'h0, 8'h40, 1'b0, {8'h00}, 0, q);
    check("undefined read", q[0], 8'hff);
    test_done();
  end
endmodule
